// File: src/ast_pkg.sv
// shared constants, field layouts and state codes of the serial transceiver
package ast_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // register byte addresses
  localparam logic [15:0] ADDR_DATA     = 16'hf290;
  localparam logic [15:0] ADDR_CONTROL  = 16'hf291;
  localparam logic [15:0] ADDR_MODE_0   = 16'hf292;
  localparam logic [15:0] ADDR_MODE_1   = 16'hf293;
  localparam logic [15:0] ADDR_BAUD_LO  = 16'hf294;
  localparam logic [15:0] ADDR_BAUD_HI  = 16'hf295;
  localparam logic [15:0] ADDR_STATUS   = 16'hf296;

  localparam logic [7:0]  RESET_BYTE    = 8'h00;
  localparam int          ENABLE_BIT    = 0;

  //////////////////////////////////////////////////////////////////////////////
  // field layouts
  typedef struct packed {
    logic [2:0] unused_hi;
    logic       rx_pin_select;
    logic       unused_3;
    logic [1:0] baud_clock_select;
    logic       direction_select;
  } ast_mode_zero_s;

  typedef struct packed {
    logic       unused_7;
    logic       msb_first;
    logic       negative_logic;
    logic       two_stop;
    logic [1:0] parity_mode;
    logic [1:0] length_field;
  } ast_mode_one_s;

  typedef struct packed {
    logic [3:0] unused_hi;
    logic       tx_buffer_full_flag;
    logic       parity_error_flag;
    logic       overrun_error_flag;
    logic       framing_error_flag;
  } ast_status_s;

  // baud clock choices; bit 1 set picks the high-speed clock
  localparam logic [1:0] CK_LOW    = 2'h0;
  localparam logic [1:0] CK_DOUBLE = 2'h1;

  // parity choices; bit 1 set means no parity bit
  localparam logic [1:0] PAR_ODD   = 2'h1;

  //////////////////////////////////////////////////////////////////////////////
  // baud generator and frame sizing
  localparam int          BAUD_W     = 12;
  localparam logic [11:0] BAUD_MIN   = 12'h008;
  localparam logic [2:0]  LAST_BIT   = 3'h7;
  localparam logic [7:0]  FULL_MASK  = 8'hff;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_START  = 5'h02,
    ST_DATA   = 5'h04,
    ST_PARITY = 5'h08,
    ST_STOP   = 5'h10
  } ast_state_e;

endpackage

// File: src/ast_baud_gen.sv
// baud rate generator: counts edges of the selected input clock
`timescale 1ns/1ps
module ast_baud_gen
  import ast_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              low_speed_clock,
  input  wire logic              low_speed_clock_x2,
  input  wire logic              high_speed_clock,
  input  wire logic [1:0]        baud_clock_select,
  input  wire logic [BAUD_W-1:0] baud_count,
  input  wire logic              restart,
  output logic                   bit_tick,
  output logic                   half_tick
);
  import ast_pkg::*;

  logic [2:0]        ck_s1;
  logic [2:0]        ck_s2;
  logic [2:0]        ck_s3;
  logic [2:0]        ck_rise;
  logic              src_edge;
  logic [BAUD_W-1:0] limit;
  logic [BAUD_W-1:0] cnt;

  //////////////////////////////////////////////////////////////////////////////
  // the source clocks are foreign: two flops, then a third for edge detection
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          ck_s1[g] <= 1'b0;
          ck_s2[g] <= 1'b0;
          ck_s3[g] <= 1'b0;
        end else begin
          ck_s1[g] <= (g == 0) ? low_speed_clock :
                      (g == 1) ? low_speed_clock_x2 : high_speed_clock;
          ck_s2[g] <= ck_s1[g];
          ck_s3[g] <= ck_s2[g];
        end
      end
      assign ck_rise[g] = ck_s2[g] & ~ck_s3[g];
    end
  endgenerate

  always_comb begin
    if (baud_clock_select[1])
      src_edge = ck_rise[2];
    else if (baud_clock_select == CK_DOUBLE)
      src_edge = ck_rise[1];
    else
      src_edge = ck_rise[0];
  end

  // small settings are lifted so a bit always spans at least nine edges
  assign limit = (baud_count < BAUD_MIN) ? BAUD_MIN : baud_count;

  //////////////////////////////////////////////////////////////////////////////
  // one bit period is limit+1 source edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
    end else if (restart) begin
      cnt <= '0;
    end else if (src_edge) begin
      cnt <= (cnt == limit) ? '0 : cnt + 1'b1;
    end
  end

  assign bit_tick  = src_edge & (cnt == limit);
  assign half_tick = src_edge & (cnt == (limit >> 1));

endmodule

// File: src/ast_transceiver.sv
// asynchronous serial transceiver: registers, transmitter and receiver
`timescale 1ns/1ps
module ast_transceiver
  import ast_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        low_speed_clock,
  input  wire logic        low_speed_clock_x2,
  input  wire logic        high_speed_clock,
  input  wire logic        rx_pin_a,
  input  wire logic        rx_pin_b,
  output logic             serial_tx_output,
  output logic             frame_irq
);
  import ast_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0]     serial_data_buffer;
  logic           comm_enable_bit;
  ast_mode_zero_s serial_mode_zero;
  ast_mode_one_s  serial_mode_one;
  logic [7:0]     baud_count_low;
  logic [7:0]     baud_count_high;
  ast_status_s    serial_status;
  logic           rx_unread;

  logic           wr_data;
  logic           wr_control;
  logic           wr_status;
  logic           rd_data;
  logic           tx_mode;
  logic           rx_mode;

  // frame shape
  logic [2:0]     last_idx;
  logic [7:0]     len_mask;
  logic           parity_on;
  logic           parity_odd;

  // baud generator
  logic           bit_tick;
  logic           half_tick;
  logic           baud_restart;

  // transmitter
  ast_state_e     tx_state;
  logic [7:0]     tx_shift;
  logic [2:0]     tx_idx;
  logic           tx_stop_cnt;
  logic           tx_load;
  logic           tx_finish;
  logic           tx_data_bit;
  logic           next_tx_bit;

  // receiver
  ast_state_e     rx_state;
  logic [1:0]     pin_s1;
  logic [1:0]     pin_s2;
  logic           rx_s2;
  logic           rx_s3;
  logic           rx_lvl;
  logic           rx_prev;
  logic           rx_fall;
  logic           rx_begin;
  logic [7:0]     rx_data;
  logic [2:0]     rx_idx;
  logic           rx_stop_cnt;
  logic           rx_frame_bad;
  logic           rx_par_bad;
  logic           rx_end;
  logic           rx_done;
  logic [2:0]     rx_pos;

  //////////////////////////////////////////////////////////////////////////////
  // decode
  assign wr_data    = reg_wr && (reg_addr == ADDR_DATA);
  assign wr_control = reg_wr && (reg_addr == ADDR_CONTROL);
  assign wr_status  = reg_wr && (reg_addr == ADDR_STATUS);
  assign rd_data    = reg_rd && (reg_addr == ADDR_DATA);
  assign tx_mode    = ~serial_mode_zero.direction_select;
  assign rx_mode    = serial_mode_zero.direction_select;

  assign last_idx   = LAST_BIT - {1'b0, serial_mode_one.length_field};
  assign len_mask   = FULL_MASK >> serial_mode_one.length_field;
  assign parity_on  = ~serial_mode_one.parity_mode[1];
  assign parity_odd = (serial_mode_one.parity_mode == PAR_ODD);

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serial_mode_zero <= RESET_BYTE;
      serial_mode_one  <= RESET_BYTE;
      baud_count_low   <= RESET_BYTE;
      baud_count_high  <= RESET_BYTE;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_MODE_0)
        serial_mode_zero <= reg_wdata;
      if (reg_addr == ADDR_MODE_1)
        serial_mode_one <= reg_wdata;
      if (reg_addr == ADDR_BAUD_LO)
        baud_count_low <= reg_wdata;
      if (reg_addr == ADDR_BAUD_HI)
        baud_count_high <= reg_wdata;
    end
  end

  // a software write in the same cycle as the end of transmission wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      comm_enable_bit <= 1'b0;
    end else if (wr_control) begin
      comm_enable_bit <= reg_wdata[ENABLE_BIT];
    end else if (tx_finish) begin
      comm_enable_bit <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // data buffer: rx_done only occurs in receive mode, writes only in transmit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serial_data_buffer <= RESET_BYTE;
    end else if (rx_done) begin
      serial_data_buffer <= rx_data & len_mask;
    end else if (wr_data && tx_mode) begin
      serial_data_buffer <= reg_wdata;
    end
  end

  // unread marker survives a disable so overrun still fires afterwards
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_unread <= 1'b0;
    end else if (rx_done) begin
      rx_unread <= 1'b1;
    end else if (rd_data) begin
      rx_unread <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status flags: hardware sets win over a clearing status write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serial_status <= RESET_BYTE;
    end else begin
      serial_status.unused_hi <= '0;
      if (wr_data && tx_mode)
        serial_status.tx_buffer_full_flag <= 1'b1;
      else if (tx_load || wr_status)
        serial_status.tx_buffer_full_flag <= 1'b0;
      if (rx_done) begin
        serial_status.framing_error_flag <= rx_frame_bad;
        serial_status.parity_error_flag  <= rx_par_bad;
      end else if (wr_status) begin
        serial_status.framing_error_flag <= 1'b0;
        serial_status.parity_error_flag  <= 1'b0;
      end
      if (rx_done && rx_unread)
        serial_status.overrun_error_flag <= 1'b1;
      else if (wr_status)
        serial_status.overrun_error_flag <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read port: data one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= RESET_BYTE;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_DATA:    reg_rdata <= serial_data_buffer;
        ADDR_CONTROL: reg_rdata <= {7'h00, comm_enable_bit};
        ADDR_MODE_0:  reg_rdata <= serial_mode_zero;
        ADDR_MODE_1:  reg_rdata <= serial_mode_one;
        ADDR_BAUD_LO: reg_rdata <= baud_count_low;
        ADDR_BAUD_HI: reg_rdata <= baud_count_high;
        // error flags read zero in transmit mode, full reads zero in receive
        ADDR_STATUS:  reg_rdata <= {4'h0,
                                    serial_status.tx_buffer_full_flag & tx_mode,
                                    serial_status.parity_error_flag & rx_mode,
                                    serial_status.overrun_error_flag & rx_mode,
                                    serial_status.framing_error_flag & rx_mode};
        default:      reg_rdata <= RESET_BYTE;
      endcase
    end else begin
      reg_rdata <= RESET_BYTE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // baud generator, shared: only one direction runs at a time
  assign baud_restart = tx_load | rx_begin;

  ast_baud_gen u_baud (
    .clk                (clk),
    .rst                (rst),
    .low_speed_clock    (low_speed_clock),
    .low_speed_clock_x2 (low_speed_clock_x2),
    .high_speed_clock   (high_speed_clock),
    .baud_clock_select  (serial_mode_zero.baud_clock_select),
    .baud_count         ({baud_count_high[3:0], baud_count_low}),
    .restart            (baud_restart),
    .bit_tick           (bit_tick),
    .half_tick          (half_tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // transmitter
  // software must wait for full to clear before the next byte, else it is lost
  assign tx_load   = (tx_state == ST_IDLE) && comm_enable_bit && tx_mode &&
                     serial_status.tx_buffer_full_flag;
  assign tx_finish = (tx_state == ST_IDLE) && comm_enable_bit && tx_mode &&
                     ~serial_status.tx_buffer_full_flag;

  assign tx_data_bit = serial_mode_one.msb_first ?
                       tx_shift[last_idx - tx_idx] : tx_shift[tx_idx];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_state    <= ST_IDLE;
      tx_shift    <= RESET_BYTE;
      tx_idx      <= '0;
      tx_stop_cnt <= 1'b0;
    end else if (!comm_enable_bit || !tx_mode) begin
      tx_state <= ST_IDLE;
    end else begin
      unique case (tx_state)
        ST_IDLE: begin
          if (tx_load) begin
            tx_shift <= serial_data_buffer;
            tx_state <= ST_START;
          end
        end
        ST_START: begin
          if (bit_tick) begin
            tx_idx   <= '0;
            tx_state <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (bit_tick) begin
            tx_idx <= tx_idx + 3'h1;
            if (tx_idx == last_idx) begin
              tx_stop_cnt <= 1'b0;
              tx_state    <= parity_on ? ST_PARITY : ST_STOP;
            end
          end
        end
        ST_PARITY: begin
          if (bit_tick)
            tx_state <= ST_STOP;
        end
        ST_STOP: begin
          if (bit_tick) begin
            if (serial_mode_one.two_stop && !tx_stop_cnt)
              tx_stop_cnt <= 1'b1;
            else
              tx_state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_comb begin
    unique case (tx_state)
      ST_IDLE:   next_tx_bit = 1'b1;
      ST_START:  next_tx_bit = 1'b0;
      ST_DATA:   next_tx_bit = tx_data_bit;
      ST_PARITY: next_tx_bit = ^(tx_shift & len_mask) ^ parity_odd;
      ST_STOP:   next_tx_bit = 1'b1;
      default:   next_tx_bit = 1'b1;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serial_tx_output <= 1'b1;
    end else begin
      serial_tx_output <= next_tx_bit ^ serial_mode_one.negative_logic;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receiver input: each pin passes two flops before the pin mux reads it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1 <= 2'h3;
      pin_s2 <= 2'h3;
      rx_s3  <= 1'b1;
    end else begin
      pin_s1 <= {rx_pin_b, rx_pin_a};
      pin_s2 <= pin_s1;
      rx_s3  <= rx_s2;
    end
  end

  assign rx_s2 = serial_mode_zero.rx_pin_select ? pin_s2[1] : pin_s2[0];

  assign rx_lvl   = rx_s2 ^ serial_mode_one.negative_logic;
  assign rx_prev  = rx_s3 ^ serial_mode_one.negative_logic;
  assign rx_fall  = rx_prev & ~rx_lvl;
  assign rx_begin = (rx_state == ST_IDLE) && comm_enable_bit && rx_mode && rx_fall;
  assign rx_pos   = serial_mode_one.msb_first ? (last_idx - rx_idx) : rx_idx;
  assign rx_end   = (rx_state == ST_STOP) && half_tick &&
                    !(serial_mode_one.two_stop && !rx_stop_cnt);

  //////////////////////////////////////////////////////////////////////////////
  // receiver sequence, sampled at the middle of each bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_state     <= ST_IDLE;
      rx_data      <= RESET_BYTE;
      rx_idx       <= '0;
      rx_stop_cnt  <= 1'b0;
      rx_frame_bad <= 1'b0;
      rx_par_bad   <= 1'b0;
    end else if (!comm_enable_bit || !rx_mode) begin
      rx_state <= ST_IDLE;
    end else begin
      unique case (rx_state)
        ST_IDLE: begin
          if (rx_begin) begin
            rx_data      <= RESET_BYTE;
            rx_frame_bad <= 1'b0;
            rx_par_bad   <= 1'b0;
            rx_state     <= ST_START;
          end
        end
        ST_START: begin
          if (half_tick) begin
            rx_frame_bad <= rx_lvl;
            rx_idx       <= '0;
            rx_state     <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (half_tick) begin
            rx_data[rx_pos] <= rx_lvl;
            rx_idx          <= rx_idx + 3'h1;
            if (rx_idx == last_idx) begin
              rx_stop_cnt <= 1'b0;
              rx_state    <= parity_on ? ST_PARITY : ST_STOP;
            end
          end
        end
        ST_PARITY: begin
          if (half_tick) begin
            rx_par_bad <= rx_lvl ^ (^(rx_data & len_mask)) ^ parity_odd;
            rx_state   <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (half_tick) begin
            if (!rx_lvl)
              rx_frame_bad <= 1'b1;
            if (rx_end)
              rx_state <= ST_IDLE;
            else
              rx_stop_cnt <= 1'b1;
          end
        end
      endcase
    end
  end

  // frame end pulse; flags see the last stop sample one cycle later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_done   <= 1'b0;
      frame_irq <= 1'b0;
    end else begin
      rx_done   <= rx_end && comm_enable_bit && rx_mode;
      frame_irq <= rx_end && comm_enable_bit && rx_mode;
    end
  end

endmodule

// File: testbench/ast_checker.sv
// checker: register port and line relations of the serial transceiver
`timescale 1ns/1ps
module ast_checker
  import ast_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        serial_tx_output,
  input wire logic        frame_irq
);
  // shadows of software writes; hardware clears enable and the full flag, so stale ones are skipped
  logic       dir, neg, en, en_ok, wrote, full;
  logic [1:0] len;
  logic [7:0] bufw;
  wire wr_ctl = reg_wr && reg_addr == ADDR_CONTROL;
  wire wr_st  = reg_wr && reg_addr == ADDR_STATUS;
  wire rd_st  = reg_rd && reg_addr == ADDR_STATUS;
  wire rd_dat = reg_rd && reg_addr == ADDR_DATA;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {dir, neg, en, en_ok, wrote, full, len, bufw} <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_MODE_0: {dir, en_ok, wrote, full} <= {reg_wdata[0], 3'h0};
        ADDR_MODE_1: {neg, len} <= {reg_wdata[5], reg_wdata[1:0]};
        ADDR_CONTROL: {en, en_ok, full} <= {reg_wdata[0], dir, 1'b0};
        ADDR_DATA: if (!dir) {wrote, full, bufw} <= {2'h3, reg_wdata};
        ADDR_STATUS: full <= 1'b0;
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  property p_irq; frame_irq |=> !frame_irq; endproperty
  a_irq: assert property (p_irq) else $error("irq wider than a cycle");
  property p_abort; wr_ctl && !reg_wdata[ENABLE_BIT] |=> ##[0:2] serial_tx_output == !neg;
  endproperty
  a_abort: assert property (p_abort) else $error("line not idle after stop");
  property p_clr; (wr_st && !frame_irq) ##1 (!reg_wr && !frame_irq) ##1 (rd_st && !frame_irq)
    |=> reg_rdata == RESET_BYTE; endproperty
  a_clr: assert property (p_clr) else $error("status not cleared");
  property p_back; rd_dat && !dir && wrote |=> reg_rdata == $past(bufw); endproperty
  a_back: assert property (p_back) else $error("buffer readback wrong");
  property p_full; rd_st && full && !en |=> reg_rdata[3]; endproperty
  a_full: assert property (p_full) else $error("full flag not set");
  property p_ctl; reg_rd && reg_addr == ADDR_CONTROL && dir && en_ok
    |=> reg_rdata[ENABLE_BIT] == $past(en); endproperty
  a_ctl: assert property (p_ctl) else $error("receive enable changed");
  property p_mask; frame_irq ##[1:20] (rd_dat && dir) |=> (reg_rdata >> (4'h8 - len)) == 8'h00;
  endproperty
  a_mask: assert property (p_mask) else $error("unused received bits set");
  property p_start; wr_ctl && reg_wdata[ENABLE_BIT] && !dir && full && !en
    |-> ##[1:4] serial_tx_output == neg; endproperty
  a_start: assert property (p_start) else $error("no start bit");
  c_irq: cover property (frame_irq);
  c_start: cover property (wr_ctl && reg_wdata[ENABLE_BIT] && !dir);
  c_clr: cover property (wr_st);
endmodule
bind ast_transceiver ast_checker ast_checker_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .serial_tx_output(serial_tx_output), .frame_irq(frame_irq));

// File: testbench/ast_remote_model.sv
// remote serial device: sends frames to and takes frames from the transceiver
`timescale 1ns/1ps
module ast_remote_model
  import ast_pkg::*;
(
  input  wire logic line_in,
  input  wire logic neg,
  output wire logic line_out
);
  logic lvl = 1'b1;
  assign line_out = lvl ^ neg;
  // flt 1 flips the parity bit, flt 2 sends a low stop bit
  task automatic send_frame(input logic [7:0] d, input ast_mode_one_s m, input int bn,
                            input int flt);
    int n;
    logic p;
    n = 8 - m.length_field;
    p = ^(d & (8'hff >> m.length_field)) ^ (m.parity_mode == PAR_ODD) ^ (flt == 1);
    lvl = 1'b0;
    #(bn);
    for (int i = 0; i < n; i++) begin
      lvl = m.msb_first ? d[n - 1 - i] : d[i];
      #(bn);
    end
    if (!m.parity_mode[1]) begin
      lvl = p;
      #(bn);
    end
    lvl = (flt != 2);
    #(bn);
    lvl = 1'b1;
    if (m.two_stop) #(bn);
  endtask
  task automatic recv_frame(input ast_mode_one_s m, input int bn, output logic [7:0] d,
                            output logic ok);
    int n;
    n = 8 - m.length_field;
    d = 8'h00;
    wait ((line_in ^ neg) === 1'b0);
    #(bn / 2);
    ok = (line_in ^ neg) === 1'b0;
    for (int i = 0; i < n; i++) begin
      #(bn);
      d[m.msb_first ? n - 1 - i : i] = line_in ^ neg;
    end
    if (!m.parity_mode[1]) begin
      #(bn);
      ok &= (^d ^ (m.parity_mode == PAR_ODD)) === (line_in ^ neg);
    end
    #(bn);
    ok &= (line_in ^ neg) === 1'b1;
    if (m.two_stop) begin
      #(bn);
      ok &= (line_in ^ neg) === 1'b1;
    end
  endtask
endmodule

// File: testbench/tb_top.sv
// testbench: register traffic, frames both ways, error flags
`timescale 1ns/1ps
module tb_top;
  import ast_pkg::*;
  typedef struct {logic [15:0] a; logic [7:0] e;} ast_note_s;
  logic clk = 0, rst = 1, wr = 0, rd = 0, rd_d = 0, lo = 0, lo2 = 0, hi = 0;
  logic neg_w = 0, rsel = 0, tx, irq, line, ok;
  logic [15:0] addr = 0;
  logic [7:0] wd = 0, rdata, d, got;
  int err_total = 0, tests_run = 0, bn;
  ast_note_s q[$], nt;
  logic [7:0] m1_t[4] = '{8'h00, 8'h35, 8'h4a, 8'h7f};
  logic [7:0] bd_t[4] = '{8'h08, 8'h03, 8'h00, 8'h0a};
  int per_t[4] = '{400, 200, 125, 125};
  int fl_t[3] = '{1, 2, 0};
  logic [7:0] st_t[3] = '{8'h04, 8'h01, 8'h02};
  initial forever #12.5 clk = ~clk;
  initial forever #200 lo = ~lo;
  initial forever #100 lo2 = ~lo2;
  initial forever #62.5 hi = ~hi;
  // the unselected receive pin idles, so a wrong pin choice loses the frame
  ast_transceiver ast_transceiver_i (.clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .low_speed_clock(lo),
    .low_speed_clock_x2(lo2), .high_speed_clock(hi), .rx_pin_a(rsel ? !neg_w : line),
    .rx_pin_b(rsel ? line : !neg_w), .serial_tx_output(tx), .frame_irq(irq));
  ast_remote_model ast_remote_model_i (.line_in(tx), .neg(neg_w), .line_out(line));
  ////////////////////////////////////////////////////////////////////////////////
  task check(input string nm, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task bus_wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wd <= v;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task bus_rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    q.push_back('{a, e});
    @(posedge clk);
    rd <= 0;
  endtask
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d === 1'b1) begin
      nt = q.pop_front();
      check($sformatf("reg %h", nt.a), nt.e, rdata);
    end
  end
  task wait_irq;
    int i;
    for (i = 0; i < 4000 && irq !== 1'b1; i++) @(negedge clk);
    check("irq", 8'h01, {7'h0, irq});
  endtask
  task setup(input int i, input logic r, input logic pb);
    bus_wr(ADDR_CONTROL, 8'h00);
    neg_w <= m1_t[i][5];
    rsel <= pb;
    bn = ((bd_t[i] < 8 ? 8 : bd_t[i]) + 1) * per_t[i];
    bus_wr(ADDR_MODE_1, m1_t[i]);
    bus_wr(ADDR_MODE_0, {3'h0, pb, 1'b0, 2'(i), r});
    bus_wr(ADDR_BAUD_LO, bd_t[i]);
    bus_wr(ADDR_BAUD_HI, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(78));
    repeat (10) @(posedge clk);
    rst <= 0;
    for (int a = 0; a < 8; a++) bus_rd(ADDR_DATA + 16'(a), 8'h00);
    for (int i = 0; i < 4; i++) begin
      setup(i, 1'b0, 1'b0);
      d = 8'($urandom);
      bus_wr(ADDR_DATA, d);
      bus_rd(ADDR_STATUS, 8'h08);
      bus_rd(ADDR_DATA, d);
      bus_rd(ADDR_BAUD_LO, bd_t[i]);
      fork
        ast_remote_model_i.recv_frame(m1_t[i], bn, got, ok);
      join_none
      bus_wr(ADDR_CONTROL, 8'h01);
      wait fork;
      check("tx data", d & (8'hff >> m1_t[i][1:0]), got);
      check("tx frame", 8'h01, {7'h0, ok});
      #(2 * bn);
      bus_rd(ADDR_CONTROL, 8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      setup(i, 1'b1, i[0]);
      bus_wr(ADDR_CONTROL, 8'h01);
      d = 8'($urandom);
      fork
        ast_remote_model_i.send_frame(d, m1_t[i], bn, 0);
      join_none
      wait_irq();
      bus_wr(ADDR_DATA, 8'hff);
      bus_rd(ADDR_DATA, d & (8'hff >> m1_t[i][1:0]));
      bus_rd(ADDR_STATUS, 8'h00);
      bus_rd(ADDR_CONTROL, 8'h01);
      wait fork;
    end
    setup(2, 1'b1, 1'b0);
    bus_wr(ADDR_MODE_1, 8'h00);
    bus_wr(ADDR_CONTROL, 8'h01);
    for (int k = 0; k < 3; k++) begin
      d = 8'($urandom);
      fork
        ast_remote_model_i.send_frame(d, 8'h00, bn, fl_t[k]);
      join_none
      wait_irq();
      bus_rd(ADDR_STATUS, st_t[k]);
      if (fl_t[k] != 2) bus_rd(ADDR_DATA, d);
      wait fork;
    end
    bus_wr(ADDR_STATUS, 8'h5a);
    bus_rd(ADDR_STATUS, 8'h00);
    end_of_test();
  end
  initial begin
    #2000000;
    err_total++;
    end_of_test();
  end
endmodule
